// file: rtl/pbh_map.svh
// Named constants for the primary bus hold and float controller.
`ifndef PBH_MAP_SVH
`define PBH_MAP_SVH
`define PBH_ADDR_W 24
`define PBH_DATA_W 32
`define PBH_FLAG_N 2
`define PBH_RESET_VECTOR 24'h000000
// Synchroniser width and idle levels: ready low, hold and shutdown released, flags 2'h1.
`define PBH_SYNC_W 5
`define PBH_SYNC_IDLE 5'h0E
// Edges a pin level needs to cross the synchroniser.
`define PBH_SYNC_DEPTH 2'h2
`endif

// file: rtl/pbh_pkg.sv
// Types shared by the primary bus hold and float controller.
package pbh_pkg;
  typedef enum logic [1:0] {
    PBH_IDLE = 2'b00,
    PBH_ACCESS = 2'b01,
    PBH_HOLD = 2'b11
  } pbh_state_t;
endpackage

// file: rtl/pbh_sync_if.sv
// Synchronised pin levels passed from the input synchroniser to the controller.
`timescale 1ns/1ns
interface pbh_sync_if;
  logic ready_s;
  logic hold_req_n_s;
  logic shutdown_float_n_s;
  logic [1:0] flag_in_s;
  modport src (output ready_s, output hold_req_n_s, output shutdown_float_n_s, output flag_in_s);
  modport dst (input ready_s, input hold_req_n_s, input shutdown_float_n_s, input flag_in_s);
endinterface

// file: rtl/pbh_sync.sv
// Two-stage synchroniser for the asynchronous control pins.
`timescale 1ns/1ns
`include "pbh_map.svh"
module pbh_sync
  import pbh_pkg::*;
#(
  parameter int W = 5
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [W-1:0] pins,
  pbh_sync_if.src sy
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s1_d;
  logic [W-1:0] s2_d;

  // The first stage feeds only the second stage.
  always_comb begin
    s1_d = pins;
    s2_d = s1_q;
  end

  // Both stages come out of reset at the idle level of each pin.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s1_q <= W'(`PBH_SYNC_IDLE);
      s2_q <= W'(`PBH_SYNC_IDLE);
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
    end
  end

  // Pin order: ready, hold request, shutdown, two flag inputs.
  assign sy.ready_s = s2_q[0];
  assign sy.hold_req_n_s = s2_q[1];
  assign sy.shutdown_float_n_s = s2_q[2];
  assign sy.flag_in_s = s2_q[4:3];
endmodule

// file: rtl/pbh_ctrl.sv
// Primary bus controller with hold handshake, pin float control and flag pins.
// How it works
// [RQ1] Direction high on reads, low on writes.
// [RQ2] Ready input completes the current bus access.
// [RQ3] Hold request: finish access, float, start nothing.
// [RQ4] Stay held until release or ignore bit.
// [RQ5] Grant goes low when pins float.
// [RQ6] Grant high on released request or ignore.
// [RQ7] Hold in reset; start fetch at vector.
// [RQ8] Acknowledge pulses only on acknowledge instruction.
// [RQ9] Shutdown stops operation and floats every pin.
// [RQ10] Reset after shutdown restores known state.
// [RQ11] Float sets per pin: shutdown, hold, reset.
// [RQ12] Flags are general I/O or interlock handshake.
// [RQ13] Strobe low until ready ends the access.
`timescale 1ns/1ns
`include "pbh_map.svh"
module pbh_ctrl
  import pbh_pkg::*;
#(
  parameter int AW = `PBH_ADDR_W,
  parameter int DW = `PBH_DATA_W
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ready,
  input wire logic hold_req_n,
  input wire logic shutdown_float_n,
  input wire logic hold_ignore_bit,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [AW-1:0] req_addr,
  input wire logic [DW-1:0] req_wdata,
  output logic rsp_valid,
  output logic [DW-1:0] rsp_rdata,
  output logic fetch_start,
  output logic [AW-1:0] fetch_addr,
  input wire logic ack_instr,
  output logic int_ack_out,
  output logic int_ack_out_oe,
  output logic [AW-1:0] address_port,
  output logic address_port_oe,
  output logic [DW-1:0] data_port_out,
  input wire logic [DW-1:0] data_port_in,
  output logic data_port_oe,
  output logic read_write,
  output logic read_write_oe,
  output logic access_strobe_n,
  output logic access_strobe_oe,
  output logic bus_hold_grant_n,
  output logic bus_hold_grant_oe,
  input wire logic [`PBH_FLAG_N-1:0] flag_mode_interlock,
  input wire logic [`PBH_FLAG_N-1:0] flag_dir_out,
  input wire logic [`PBH_FLAG_N-1:0] flag_out_val,
  input wire logic [`PBH_FLAG_N-1:0] interlock_out,
  output logic [`PBH_FLAG_N-1:0] interlock_in,
  output logic [`PBH_FLAG_N-1:0] flag_in_val,
  output logic [`PBH_FLAG_N-1:0] external_flag_pins_out,
  input wire logic [`PBH_FLAG_N-1:0] external_flag_pins_in,
  output logic [`PBH_FLAG_N-1:0] external_flag_pins_oe
);
  pbh_sync_if sy();
  pbh_state_t st_q, st_d;
  logic [AW-1:0] addr_q, addr_d;
  logic [DW-1:0] wdata_q, wdata_d, rdata_q, rdata_d;
  logic write_q, write_d, rsp_q, rsp_d, ack_q, ack_d, run_q, run_d, fetch_q, fetch_d;
  logic [`PBH_FLAG_N-1:0] fout_q, fout_d;
  logic [1:0] settle_q, settle_d;
  logic hold_want, active, in_reset;

  // True while the sequencer owns the bus for one access; shared by strobe and data drivers.
  function automatic logic pbh_in_access(input pbh_state_t s);
    return s == PBH_ACCESS;
  endfunction

  // Asynchronous pins are synchronised before any logic reads them.
  pbh_sync #(.W(`PBH_SYNC_W)) u_sync (
    .clk(clk),
    .rstn(rstn),
    .pins({external_flag_pins_in, shutdown_float_n, hold_req_n, ready}),
    .sy(sy)
  );

  // Shutdown stops all operation; a hold wins only while the ignore bit is clear.
  assign active = sy.shutdown_float_n_s; // RQ9
  assign in_reset = !run_q; // RQ7
  assign hold_want = !sy.hold_req_n_s && !hold_ignore_bit; // RQ4

  // Bus sequencer: idle, one extended access, or held off the bus.
  always_comb begin
    st_d = st_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    write_d = write_q;
    rdata_d = rdata_q;
    settle_d = settle_q;
    rsp_d = 1'b0;
    ack_d = 1'b0;
    run_d = 1'b1;
    fetch_d = !run_q;
    req_ready = 1'b0;
    if (!active) begin
      st_d = PBH_IDLE;
      fetch_d = 1'b0;
      run_d = run_q;
    end else begin
      ack_d = ack_instr; // RQ8
      unique case (st_q)
        PBH_IDLE: begin
          if (hold_want) begin
            st_d = PBH_HOLD; // RQ3
          end else if (!in_reset) begin
            req_ready = 1'b1;
            if (req_valid) begin
              st_d = PBH_ACCESS;
              addr_d = req_addr;
              wdata_d = req_wdata;
              write_d = req_write;
              settle_d = '0;
            end
          end
        end
        PBH_ACCESS: begin
          // Ready needs two synchroniser edges, so the first two edges of an access
          // could still see the ready of the access before; they are skipped.
          if (settle_q != `PBH_SYNC_DEPTH) begin
            settle_d = settle_q + 2'h1; // RQ2
          end else if (sy.ready_s) begin
            st_d = PBH_IDLE; // RQ2
            rsp_d = 1'b1;
            if (!write_q) begin
              rdata_d = data_port_in;
            end
          end
        end
        PBH_HOLD: begin
          if (!hold_want) begin
            st_d = PBH_IDLE; // RQ4
          end
        end
        default: st_d = PBH_IDLE;
      endcase
    end
  end

  // State registers; reset gives a known state after any shutdown.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= PBH_IDLE; // RQ10
      addr_q <= '0;
      wdata_q <= '0;
      rdata_q <= '0;
      write_q <= 1'b0;
      rsp_q <= 1'b0;
      ack_q <= 1'b0;
      run_q <= 1'b0;
      fetch_q <= 1'b0;
      settle_q <= '0;
    end else begin
      st_q <= st_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      rdata_q <= rdata_d;
      write_q <= write_d;
      rsp_q <= rsp_d;
      ack_q <= ack_d;
      run_q <= run_d;
      fetch_q <= fetch_d;
      settle_q <= settle_d;
    end
  end

  // Core side outputs.
  assign rsp_valid = rsp_q;
  assign rsp_rdata = rdata_q;
  assign fetch_start = fetch_q; // RQ7
  assign fetch_addr = `PBH_RESET_VECTOR;

  // Bus pins: drivers float under shutdown, hold and reset as listed per pin.
  assign address_port = addr_q;
  assign data_port_out = wdata_q;
  assign read_write = !write_q; // RQ1
  assign access_strobe_n = !pbh_in_access(st_q); // RQ13
  assign address_port_oe = active && st_q != PBH_HOLD && !in_reset; // RQ11
  assign read_write_oe = address_port_oe; // RQ11
  assign data_port_oe = address_port_oe && pbh_in_access(st_q) && write_q; // RQ11
  assign access_strobe_oe = active && st_q != PBH_HOLD; // RQ11
  assign bus_hold_grant_n = !(st_q == PBH_HOLD); // RQ5 RQ6
  assign bus_hold_grant_oe = active; // RQ11
  assign int_ack_out = !ack_q; // RQ8
  assign int_ack_out_oe = active; // RQ9

  // Flag output register reloads the selected flag value on every clock edge.
  always_comb begin
    fout_d = fout_q;
    for (int i = 0; i < `PBH_FLAG_N; i++) begin
      fout_d[i] = flag_mode_interlock[i] ? interlock_out[i] : flag_out_val[i]; // RQ12
    end
  end

  // Flag output register; reset leaves every flag low.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fout_q <= '0;
    end else begin
      fout_q <= fout_d;
    end
  end

  // Each flag pin serves general I/O or the interlock handshake.
  genvar g;
  generate
    for (g = 0; g < `PBH_FLAG_N; g++) begin : g_flag
      // An interlock pin drives outside shutdown and reset; a general pin drives only when also set as output.
      assign external_flag_pins_out[g] = fout_q[g];
      assign external_flag_pins_oe[g] = active && !in_reset
        && (flag_mode_interlock[g] || flag_dir_out[g]); // RQ11 RQ12
      assign flag_in_val[g] = sy.flag_in_s[g];
      assign interlock_in[g] = sy.flag_in_s[g] && flag_mode_interlock[g]; // RQ12
    end
  endgenerate
endmodule

// file: bench/pbh_ctrl_asserts.sv
// Concurrent checks on the primary bus controller ports.
`timescale 1ns/1ns
module pbh_ctrl_asserts
  import pbh_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic shutdown_float_n,
  input wire logic hold_ignore_bit,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic req_write,
  input wire logic rsp_valid,
  input wire logic ack_instr,
  input wire logic int_ack_out,
  input wire logic address_port_oe,
  input wire logic read_write,
  input wire logic access_strobe_n,
  input wire logic access_strobe_oe,
  input wire logic bus_hold_grant_n,
  input wire logic bus_hold_grant_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // Access, hold and float relations between the pins.
  rw_dir_a: assert property (
    req_valid && req_ready |=> read_write != $past(req_write)) else $error("dir");
  strobe_on_a: assert property (
    req_valid && req_ready |=> !access_strobe_n) else $error("strobe");
  strobe_end_a: assert property (
    rsp_valid |-> access_strobe_n && !$past(access_strobe_n)) else $error("end");
  hold_float_a: assert property (
    !bus_hold_grant_n |-> !address_port_oe && !access_strobe_oe) else $error("float");
  held_idle_a: assert property (!bus_hold_grant_n |-> !req_ready) else $error("held");
  ignore_a: assert property (hold_ignore_bit [*2] |-> bus_hold_grant_n) else $error("ign");
  ack_cause_a: assert property (!int_ack_out |-> $past(ack_instr)) else $error("ack");
  shz_float_a: assert property (
    !shutdown_float_n [*5] |-> !address_port_oe && !access_strobe_oe && !bus_hold_grant_oe)
    else $error("shz");
  cover property (rsp_valid);
  cover property (!bus_hold_grant_n);
  cover property (!int_ack_out);
endmodule
bind pbh_ctrl pbh_ctrl_asserts u_pbh_ctrl_asserts (.*);

// file: bench/pbh_mem_model.sv
// Far-side memory that answers accesses after a chosen delay.
`timescale 1ns/1ns
module pbh_mem_model (
  input wire logic clk,
  input wire logic [3:0] wait_cyc,
  input wire logic access_strobe_n,
  input wire logic read_write,
  input wire logic [23:0] address_port,
  output logic ready,
  output logic [31:0] data_port_in
);
  logic [3:0] cnt_q;
  // Counts strobe cycles so that ready can come promptly or slowly.
  always_ff @(posedge clk) cnt_q <= access_strobe_n ? 4'h0 : cnt_q + 4'h1;
  assign ready = !access_strobe_n && cnt_q >= wait_cyc;
  // Inverse pattern while selected for a read; the plain pattern otherwise.
  assign data_port_in = {8'h5A, address_port} ^ {32{!access_strobe_n && read_write}};
endmodule

// file: bench/pbh_ctrl_test.sv
// Self-checking bench for the primary bus hold and float controller.
`timescale 1ns/1ns
`include "pbh_map.svh"
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin n_fail++; \
  $display("mismatch %s exp %0h got %0h", n, e, a); end end
module pbh_ctrl_test;
  import pbh_pkg::*;
  logic clk = 1'h0, rstn = 1'h0, hold_req_n = 1'h1, shutdown_float_n = 1'h1;
  logic hold_ignore_bit = 1'h0, req_valid = 1'h0, req_write = 1'h0, ack_instr = 1'h0;
  logic [23:0] req_addr = 24'h0, fetch_addr, address_port;
  logic [31:0] req_wdata = 32'h0, rsp_rdata, data_port_out, data_port_in;
  logic [1:0] flag_mode_interlock = 2'h0, flag_dir_out = 2'h0, flag_out_val = 2'h0;
  logic [1:0] interlock_out = 2'h0, external_flag_pins_in = 2'h0, interlock_in, flag_in_val;
  logic [1:0] external_flag_pins_out, external_flag_pins_oe;
  logic ready, req_ready, rsp_valid, fetch_start, int_ack_out, int_ack_out_oe, address_port_oe;
  logic data_port_oe, read_write, read_write_oe, access_strobe_n, access_strobe_oe;
  logic bus_hold_grant_n, bus_hold_grant_oe;
  logic [3:0] wait_cyc = 4'h1;
  int n_fail = 0, tests_run = 0, k;
  pbh_ctrl u_pbh_ctrl (.*);
  pbh_mem_model u_pbh_mem_model (.*);
  // Clock and watchdog.
  initial forever #5 clk = ~clk;
  initial begin
    #200000;
    n_fail++;
    close_out();
  end
  task automatic close_out();
    if (n_fail == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wait_for(ref logic s, input logic v);
    k = 0;
    while (s !== v && k < 40) begin
      @(negedge clk);
      k++;
    end
    `CHK("wait", 1'h1, k < 40)
  endtask
  task automatic t_reset();
    rstn = 1'h0;
    repeat (2) @(negedge clk);
    `CHK("rw oe", 1'h0, read_write_oe)
    `CHK("reset bus oe", 2'h0, {address_port_oe, data_port_oe})
    `CHK("reset kept oe", 2'h3, {access_strobe_oe, bus_hold_grant_oe})
    `CHK("reset flag oe", 2'h0, external_flag_pins_oe)
    `CHK("reset idle", 1'h0, req_ready)
    rstn = 1'h1;
    wait_for(fetch_start, 1'h1);
    `CHK("vector", `PBH_RESET_VECTOR, fetch_addr)
  endtask
  task automatic t_acc(input logic w, input logic [23:0] a, input logic [3:0] wc);
    wait_cyc = wc;
    req_write = w;
    req_addr = a;
    req_wdata = {8'h5A, a};
    req_valid = 1'h1;
    wait_for(req_ready, 1'h1);
    @(negedge clk);
    req_valid = 1'h0;
    `CHK("dir", !w, read_write)
    `CHK("strobe", 1'h0, access_strobe_n)
    `CHK("addr", a, address_port)
    `CHK("wdata", {w, 8'h5A, a}, {data_port_oe, data_port_out})
    wait_for(rsp_valid, 1'h1);
    `CHK("strobe off", 1'h1, access_strobe_n)
    `CHK("slow", 1'h1, k > wc)
    if (!w) `CHK("rdata", ~{8'h5A, a}, rsp_rdata)
  endtask
  task automatic t_hold();
    fork
      t_acc(1'h1, 24'h0ABCDE, 4'h6);
      begin
        repeat (3) @(negedge clk);
        hold_req_n = 1'h0;
        repeat (4) @(negedge clk);
        `CHK("grant early", 1'h1, bus_hold_grant_n)
      end
    join
    wait_for(bus_hold_grant_n, 1'h0);
    `CHK("float", 1'h0, address_port_oe)
    hold_ignore_bit = 1'h1;
    repeat (2) @(negedge clk);
    `CHK("ignore", 1'h1, bus_hold_grant_n)
    hold_ignore_bit = 1'h0;
    wait_for(bus_hold_grant_n, 1'h0);
    `CHK("held", 1'h0, req_ready)
    hold_req_n = 1'h1;
    wait_for(bus_hold_grant_n, 1'h1);
  endtask
  task automatic t_misc();
    ack_instr = 1'h1;
    flag_dir_out = 2'h1;
    flag_out_val = 2'h1;
    external_flag_pins_in = 2'h2;
    @(negedge clk);
    ack_instr = 1'h0;
    `CHK("ack on", 1'h0, int_ack_out)
    repeat (4) @(negedge clk);
    `CHK("ack off", 1'h1, int_ack_out)
    `CHK("flag oe", 2'h1, external_flag_pins_oe)
    `CHK("flag io", 2'h3, {flag_in_val[1], external_flag_pins_out[0]})
    flag_mode_interlock = 2'h2;
    interlock_out = 2'h2;
    @(negedge clk);
    `CHK("interlock", 6'h3E, {external_flag_pins_oe, external_flag_pins_out, interlock_in})
    shutdown_float_n = 1'h0;
    repeat (6) @(negedge clk);
    `CHK("shz", 8'h0, {address_port_oe, data_port_oe, read_write_oe, access_strobe_oe,
      bus_hold_grant_oe, int_ack_out_oe, external_flag_pins_oe})
    shutdown_float_n = 1'h1;
    repeat (3) @(negedge clk);
    t_reset();
  endtask
  // Main sequence.
  initial begin
    @(negedge clk);
    t_reset();
    t_acc(1'h1, 24'hFFFFFF, 4'h0);
    t_acc(1'h0, 24'h000001, 4'h8);
    t_hold();
    t_misc();
    t_acc(1'h0, 24'h123456, 4'h2);
    close_out();
  end
endmodule
